// ==== design/fdsc_pkg.sv ====
// Package of register map, field positions and timing constants for the drive-side control block.
package fdsc_pkg;

    // Register byte addresses on the APB slave.
    localparam logic [11:0] FDSC_CTRL_ADDR   = 12'h000;
    localparam logic [11:0] FDSC_CMD_ADDR    = 12'h004;
    localparam logic [11:0] FDSC_STATUS_ADDR = 12'h008;
    localparam logic [11:0] FDSC_TRACK_ADDR  = 12'h00c;
    localparam logic [11:0] FDSC_PRECOMP_ADDR = 12'h010;

    // Control register fields.
    localparam int FDSC_CTRL_HLOAD = 0;
    localparam int FDSC_CTRL_WDATA = 1;

    // Command register fields and codes.
    localparam int FDSC_CMD_LSB = 0;
    localparam logic [2:0] FDSC_CMD_NONE   = 3'h0;
    localparam logic [2:0] FDSC_CMD_STEPIN = 3'h1;
    localparam logic [2:0] FDSC_CMD_STEPOUT = 3'h2;
    localparam logic [2:0] FDSC_CMD_READ   = 3'h3;
    localparam logic [2:0] FDSC_CMD_WRITE  = 3'h4;
    localparam logic [2:0] FDSC_CMD_STOP   = 3'h5;

    // Status register bit positions.
    localparam int FDSC_ST_BUSY      = 0;
    localparam int FDSC_ST_INDEX     = 1;
    localparam int FDSC_ST_TRACK0    = 2;
    localparam int FDSC_ST_HEADENG   = 5;
    localparam int FDSC_ST_WFAULT    = 3;
    localparam int FDSC_ST_WPROT     = 6;
    localparam int FDSC_ST_NOTREADY  = 7;
    localparam int FDSC_ST_SINGLE    = 8;
    localparam int FDSC_ST_INNER     = 9;
    localparam int FDSC_ST_WGATE     = 10;
    localparam int FDSC_ST_INTERRUPT_REQUEST_OUT     = 11;

    // Track range for the inner-track flag.
    localparam logic [6:0] FDSC_INNER_LO = 7'd44;
    localparam logic [6:0] FDSC_INNER_HI = 7'd76;

    // Timing: clock rate, index low minimum and step pulse width.
    localparam int FDSC_CLK_MHZ      = 25;
    localparam int FDSC_INDEX_MIN_US = 10;
    localparam int FDSC_INDEX_CYC    = FDSC_INDEX_MIN_US * FDSC_CLK_MHZ;
    localparam int FDSC_STEP_US      = 4;
    localparam int FDSC_STEP_CYC     = FDSC_STEP_US * FDSC_CLK_MHZ;
    localparam int FDSC_DIR_SETUP_CYC = 25;

    // Controller states.
    typedef enum logic [2:0] {
        FDSC_IDLE,
        FDSC_DIRSET,
        FDSC_STEPHI,
        FDSC_READING,
        FDSC_WRITING
    } fdsc_state_t;

endpackage : fdsc_pkg

// ==== design/fdsc_top.sv ====
// Drive-side control block: stepping, write gate, precompensation hints and drive sensing.
//
// Behaviour
// - Head counts as engaged only while head-engaged input samples high.
// - One step pulse is emitted per commanded single-track move.
// - Direction high stepping inward, low stepping outward.
// - Early output high during write pulses to be shifted earlier.
// - Late output high during write pulses to be shifted later.
// - Inner-track flag shows head on tracks 44 to 76.
// - Write gate asserted only while actually writing the diskette.
// - Ready is sampled high before any read or write starts.
// - Ready low at read/write start skips operation and interrupts.
// - Seeks proceed regardless of the ready level.
// - Ready is reported inverted as a readable status bit.
// - Falling write fault while gate on ends write, sets fault bit.
// - Low track-zero input means head sits over track 00.
// - Index low for at least 10 us is an index event.
// - Write protect low at write command ends it and sets bit.
// - Density select 0 means double density, 1 single density.
// - Not-ready sits in status bit 7, cleared during master reset.
// - Interrupt set on completion or termination, cleared by command write or status read.
// - Head load output presses the head against the media.
//
// Our own choices: the address map and register access over APB.
module fdsc_top
    import fdsc_pkg::*;
#(
    parameter int INDEX_CYC = FDSC_INDEX_CYC
)
(
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        MASTER_RESET_N_IN,
    input  wire logic        HEAD_ENGAGED_IN,
    input  wire logic        READY_IN,
    input  wire logic        WRITE_FAULT_N_IN,
    input  wire logic        TRACK_ZERO_N_IN,
    input  wire logic        INDEX_MARK_N_IN,
    input  wire logic        WRITE_PROTECT_N_IN,
    input  wire logic        DENSITY_SELECT_IN,
    output logic             HEAD_LOAD_OUT,
    output logic             STEP_OUT,
    output logic             STEP_DIRECTION_OUT,
    output logic             EARLY_OUT,
    output logic             LATE_OUT,
    output logic             INNER_TRACK_FLAG,
    output logic             WRITE_GATE_OUT,
    output logic             WRITE_DATA_OUT,
    output logic             INTERRUPT_REQUEST_OUT
);

    // Two-stage synchronisers; only the second stage is ever read.
    logic [6:0] sync1_q;
    logic [6:0] sync2_q;
    wire  [6:0] raw_in = {DENSITY_SELECT_IN, WRITE_PROTECT_N_IN, INDEX_MARK_N_IN,
                          TRACK_ZERO_N_IN, WRITE_FAULT_N_IN, READY_IN, HEAD_ENGAGED_IN};
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            sync1_q <= 7'h7e;
            sync2_q <= 7'h7e;
        end
        else
        begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    wire head_eng  = sync2_q[0];
    wire ready_s   = sync2_q[1];
    wire wfault_n  = sync2_q[2];
    wire trk0_s    = ~sync2_q[3];
    wire index_n   = sync2_q[4];
    wire wprot_s   = ~sync2_q[5];
    wire single_s  = sync2_q[6];
    wire mr_active = ~MASTER_RESET_N_IN;

    // APB decode; all accesses complete with no wait states.
    wire       apb_acc   = PSEL & PENABLE;
    wire       apb_wr    = apb_acc & PWRITE;
    wire       apb_rd    = apb_acc & ~PWRITE;
    wire       hit_ctrl  = PADDR == FDSC_CTRL_ADDR;
    wire       hit_cmd   = PADDR == FDSC_CMD_ADDR;
    wire       hit_stat  = PADDR == FDSC_STATUS_ADDR;
    wire       hit_trk   = PADDR == FDSC_TRACK_ADDR;
    wire       hit_pre   = PADDR == FDSC_PRECOMP_ADDR;
    wire       hit_any   = hit_ctrl | hit_cmd | hit_stat | hit_trk | hit_pre;
    wire       cmd_wr    = apb_wr & hit_cmd;
    wire [2:0] cmd_code  = PWDATA[FDSC_CMD_LSB +: 3];
    wire       stat_rd   = apb_rd & hit_stat;
    assign PREADY  = 1'b1;
    assign PSLVERR = apb_acc & ~hit_any;

    // Software registers.
    logic [1:0] ctrl_q;
    logic [1:0] precomp_q;
    logic [6:0] track_q;
    logic       wfault_q;
    logic       wprot_q;
    logic       interrupt_request_out_q;
    logic       index_q;
    logic       wf_prev_q;
    logic [7:0] step_cnt_q;
    logic [15:0] idx_cnt_q;
    fdsc_state_t state_q;
    fdsc_state_t state_d;

    // Command acceptance in the idle state, stop while reading or writing, and end-of-operation conditions.
    wire start_seek  = cmd_wr & (state_q == FDSC_IDLE) &
                       (cmd_code == FDSC_CMD_STEPIN || cmd_code == FDSC_CMD_STEPOUT);
    wire step_in     = cmd_code == FDSC_CMD_STEPIN;
    wire rw_cmd      = cmd_wr & (state_q == FDSC_IDLE) &
                       (cmd_code == FDSC_CMD_READ || cmd_code == FDSC_CMD_WRITE);
    wire rw_go       = rw_cmd & ready_s;
    wire rw_skip     = rw_cmd & ~ready_s;
    wire wr_blocked  = rw_go & (cmd_code == FDSC_CMD_WRITE) & wprot_s;
    wire wf_fall     = (state_q == FDSC_WRITING) & wf_prev_q & ~wfault_n;
    wire stop_cmd    = cmd_wr & (cmd_code == FDSC_CMD_STOP) &
                       (state_q == FDSC_READING || state_q == FDSC_WRITING);
    wire step_done   = (state_q == FDSC_STEPHI) && (step_cnt_q == 8'd0);
    wire op_end      = step_done | rw_skip | wr_blocked | wf_fall | stop_cmd;
    wire dir_done    = (state_q == FDSC_DIRSET) && (step_cnt_q == 8'd0);

    // Next-state logic for the stepping and read/write sequencer.
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            FDSC_IDLE:
            begin
                if (start_seek)
                    state_d = FDSC_DIRSET;
                else if (rw_go && !wr_blocked)
                    state_d = (cmd_code == FDSC_CMD_WRITE) ? FDSC_WRITING : FDSC_READING;
            end
            FDSC_DIRSET:  if (dir_done)  state_d = FDSC_STEPHI;
            FDSC_STEPHI:  if (step_done) state_d = FDSC_IDLE;
            FDSC_READING: if (stop_cmd)  state_d = FDSC_IDLE;
            FDSC_WRITING: if (stop_cmd || wf_fall) state_d = FDSC_IDLE;
            // Unused state codes fall back to idle rather than lock up.
            default:      state_d = FDSC_IDLE;
        endcase
    end

    // Sequencer state, step timing and track position.
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state_q    <= FDSC_IDLE;
            step_cnt_q <= 8'h00;
            track_q    <= 7'h00;
            STEP_DIRECTION_OUT <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (start_seek)
            begin
                STEP_DIRECTION_OUT <= step_in;
                step_cnt_q <= 8'(FDSC_DIR_SETUP_CYC - 1);
            end
            else if (dir_done)
                step_cnt_q <= 8'(FDSC_STEP_CYC - 1);
            else if (step_cnt_q != 8'd0)
                step_cnt_q <= step_cnt_q - 8'd1;
            if (step_done)
            begin
                if (STEP_DIRECTION_OUT)
                    track_q <= track_q + 7'd1;
                else if (track_q != 7'd0)
                    track_q <= track_q - 7'd1;
            end
            else if (trk0_s && state_q == FDSC_IDLE)
                track_q <= 7'd0;
        end
    end

    // One pulse per move; direction is held constant across it.
    assign STEP_OUT = state_q == FDSC_STEPHI;
    assign WRITE_GATE_OUT = state_q == FDSC_WRITING;
    assign INNER_TRACK_FLAG = (track_q >= FDSC_INNER_LO) && (track_q <= FDSC_INNER_HI);
    assign HEAD_LOAD_OUT = ctrl_q[FDSC_CTRL_HLOAD];
    assign WRITE_DATA_OUT = WRITE_GATE_OUT & ctrl_q[FDSC_CTRL_WDATA];
    assign EARLY_OUT = WRITE_DATA_OUT & precomp_q[0];
    assign LATE_OUT  = WRITE_DATA_OUT & precomp_q[1] & ~precomp_q[0];
    assign INTERRUPT_REQUEST_OUT = interrupt_request_out_q;

    // Sticky flags; a hardware set wins over a same-cycle clear.
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ctrl_q    <= 2'h0;
            precomp_q <= 2'h0;
            wfault_q  <= 1'b0;
            wprot_q   <= 1'b0;
            interrupt_request_out_q   <= 1'b0;
            wf_prev_q <= 1'b1;
        end
        else
        begin
            wf_prev_q <= wfault_n;
            if (apb_wr && hit_ctrl)
                ctrl_q <= PWDATA[1:0];
            if (apb_wr && hit_pre)
                precomp_q <= PWDATA[1:0];
            if (wf_fall)
                wfault_q <= 1'b1;
            else if (cmd_wr)
                wfault_q <= 1'b0;
            if (wr_blocked)
                wprot_q <= 1'b1;
            else if (cmd_wr)
                wprot_q <= 1'b0;
            if (op_end)
                interrupt_request_out_q <= 1'b1;
            else if (cmd_wr || stat_rd)
                interrupt_request_out_q <= 1'b0;
        end
    end

    // Index detector: low must last the minimum time before it counts.
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            idx_cnt_q <= 16'h0000;
            index_q   <= 1'b0;
        end
        else if (index_n)
        begin
            idx_cnt_q <= 16'h0000;
            index_q   <= 1'b0;
        end
        else if (idx_cnt_q < 16'(INDEX_CYC - 1))
            idx_cnt_q <= idx_cnt_q + 16'd1;
        else
            index_q <= 1'b1;
    end

    // Status word; not-ready is forced clear while master reset is held.
    wire [31:0] status_w = {20'h00000, interrupt_request_out_q, WRITE_GATE_OUT, INNER_TRACK_FLAG, single_s,
                            ~ready_s & ~mr_active, wprot_q, head_eng, 1'b0, wfault_q,
                            trk0_s, index_q, state_q != FDSC_IDLE};
    wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_q} :
                         hit_stat ? status_w :
                         hit_trk  ? {25'h0, track_q} :
                         hit_pre  ? {30'h0, precomp_q} : 32'h0;

    // Read data registered on each read access.
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
            PRDATA <= 32'h0;
        else if (PSEL && !PENABLE && !PWRITE)
            PRDATA <= rd_mux;
    end

    // Interrupt follows any termination within one edge.
    AST_INTERRUPT_REQUEST_OUT: assert property (@(posedge CLOCK) disable iff (!RSTN)
        op_end |=> INTERRUPT_REQUEST_OUT) else $error("interrupt missing");
    AST_STEP_LEN: assert property (@(posedge CLOCK) disable iff (!RSTN)
        $rose(STEP_OUT) |-> STEP_OUT [*8]) else $error("step too short");
    AST_DIR_STABLE: assert property (@(posedge CLOCK) disable iff (!RSTN)
        STEP_OUT |-> $stable(STEP_DIRECTION_OUT)) else $error("dir moved");
    AST_NOTREADY_RW: assert property (@(posedge CLOCK) disable iff (!RSTN)
        rw_cmd && !ready_s |=> state_q == FDSC_IDLE) else $error("rw started");
    AST_WG_ONLY: assert property (@(posedge CLOCK) disable iff (!RSTN)
        $rose(WRITE_GATE_OUT) |->
        $past(cmd_wr && cmd_code == FDSC_CMD_WRITE && ready_s && !wprot_s))
        else $error("wg stray");
    AST_WF_END: assert property (@(posedge CLOCK) disable iff (!RSTN)
        wf_fall |=> !WRITE_GATE_OUT && wfault_q) else $error("fault ignored");
    AST_WP: assert property (@(posedge CLOCK) disable iff (!RSTN)
        wr_blocked |=> wprot_q && !WRITE_GATE_OUT) else $error("protect ignored");
    AST_INNER: assert property (@(posedge CLOCK) disable iff (!RSTN)
        INNER_TRACK_FLAG |-> track_q > 7'd43 && track_q < 7'd77) else $error("inner bad");
    AST_SEEK: assert property (@(posedge CLOCK) disable iff (!RSTN)
        start_seek |=> state_q == FDSC_DIRSET) else $error("seek refused");

endmodule : fdsc_top

// ==== dv/fdsc_drive_model.sv ====
// Behavioural model of the floppy drive that faces the drive-side control block.
module fdsc_drive_model
(
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       step,
    input  wire logic       dir,
    input  wire logic       wgate,
    input  wire logic       hload,
    input  wire logic       ready_set,
    input  wire logic       wprot_set,
    input  wire logic       fault_set,
    input  wire logic [7:0] index_len,
    output logic            ready,
    output logic            head_eng,
    output logic            wf_n,
    output logic            trk0_n,
    output logic            idx_n,
    output logic            wp_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] trk_q;
    logic       step_q;
    logic [1:0] hcnt_q;
    logic [7:0] icnt_q;

    // Head position follows step edges; the head settles a few cycles after loading.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            trk_q  <= 7'h00;
            step_q <= 1'b0;
            hcnt_q <= 2'h0;
            icnt_q <= 8'h00;
        end
        else
        begin
            step_q <= step;
            if (step && !step_q)
                trk_q <= dir ? trk_q + 7'h01 : ((trk_q != 7'h00) ? trk_q - 7'h01 : 7'h00);
            hcnt_q <= !hload ? 2'h0 : ((hcnt_q != 2'h3) ? hcnt_q + 2'h1 : hcnt_q);
            icnt_q <= (index_len != 8'h00) ? index_len : ((icnt_q != 8'h00) ? icnt_q - 8'h01 : 8'h00);
        end
    end

    // Fault is only shown while the gate is on, so it goes inactive when the gate drops.
    assign wf_n     = !(wgate && fault_set);
    assign idx_n    = (icnt_q == 8'h00);
    assign head_eng = hload && (hcnt_q == 2'h3);
    assign trk0_n   = (trk_q != 7'h00);
    assign ready    = ready_set;
    assign wp_n     = !wprot_set;
endmodule : fdsc_drive_model

// ==== dv/fdsc_top_tb_top.sv ====
// Self-checking testbench of the drive-side control block with a drive model.
module fdsc_top_tb_top;
    import fdsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, last_err, mr_n = 1'b0, dens = 1'b0;
    logic        rdy_s = 1'b0, wp_s = 1'b0, wf_s = 1'b0;
    logic [7:0]  idx_len = 8'h00;
    logic        head_eng, rdy, wf_n, trk0_n, idx_n, wp_n, hload, step, dir, wgate;
    logic        early, late, inner, wdata, irq, dir_at_step;
    int          errors = 0, checks_done = 0, steps = 0;

    fdsc_top #(.INDEX_CYC(4)) fdsc_top_i (.CLOCK(clock), .RSTN(rstn), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .MASTER_RESET_N_IN(mr_n), .HEAD_ENGAGED_IN(head_eng),
        .READY_IN(rdy), .WRITE_FAULT_N_IN(wf_n), .TRACK_ZERO_N_IN(trk0_n), .INDEX_MARK_N_IN(idx_n),
        .WRITE_PROTECT_N_IN(wp_n), .DENSITY_SELECT_IN(dens), .HEAD_LOAD_OUT(hload),
        .STEP_OUT(step), .STEP_DIRECTION_OUT(dir), .EARLY_OUT(early), .LATE_OUT(late),
        .INNER_TRACK_FLAG(inner), .WRITE_GATE_OUT(wgate), .WRITE_DATA_OUT(wdata),
        .INTERRUPT_REQUEST_OUT(irq));
    fdsc_drive_model fdsc_drive_model_i (.clock(clock), .rstn(rstn), .step(step), .dir(dir),
        .wgate(wgate), .hload(hload), .ready_set(rdy_s), .wprot_set(wp_s), .fault_set(wf_s),
        .index_len(idx_len), .ready(rdy), .head_eng(head_eng), .wf_n(wf_n), .trk0_n(trk0_n),
        .idx_n(idx_n), .wp_n(wp_n));

    // Clock generator at 25 MHz.
    always #20 clock = ~clock;

    // Count step pulses and catch a direction change while a pulse stands.
    always @(posedge step)
    begin
        steps++;
        dir_at_step = dir;
    end
    always @(negedge step) check(dir, dir_at_step);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc

    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin errors++; results(); end
        q = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cmd(input logic [2:0] c);
        apb(1'b1, FDSC_CMD_ADDR, {29'h0, c});
    endtask : cmd

    task automatic stat(input int bit_pos, input logic exp);
        apb(1'b0, FDSC_STATUS_ADDR, 32'h0);
        check(q[bit_pos], exp);
    endtask : stat

    // Bounded wait for the interrupt; running out ends the run.
    // At least one edge passes first, so a request that the command just cleared is not seen stale.
    task automatic wait_irq();
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (irq !== 1'b1 && n < 400);
        if (n >= 400)
        begin
            errors++;
            results();
        end
    endtask : wait_irq

    initial
    begin
        cyc(20);
        rstn <= 1'b1;
        // Let the low ready level through the synchronisers so only master reset hides it.
        cyc(3);
        stat(FDSC_ST_NOTREADY, 1'b0);
        mr_n <= 1'b1;
        cyc(3);
        stat(FDSC_ST_NOTREADY, 1'b1);
        $display("test reset done");
        // Seeks run with ready low; each move gives one pulse and one track.
        for (int i = 1; i <= 77; i++)
        begin
            cmd(FDSC_CMD_STEPIN);
            wait_irq();
            check(dir_at_step, 1'b1);
            check(steps, i);
            check(inner, (i >= 44 && i <= 76));
        end
        stat(FDSC_ST_TRACK0, 1'b0);
        stat(FDSC_ST_INTERRUPT_REQUEST_OUT, 1'b0);
        for (int i = 76; i >= 0; i--)
        begin
            cmd(FDSC_CMD_STEPOUT);
            wait_irq();
            check(dir_at_step, 1'b0);
        end
        apb(1'b0, FDSC_TRACK_ADDR, 32'h0);
        check(q, 32'h0);
        cyc(3);
        stat(FDSC_ST_TRACK0, 1'b1);
        $display("test seek done");
        // Read with drive not ready is skipped and interrupts.
        cmd(FDSC_CMD_READ);
        wait_irq();
        check(wgate, 1'b0);
        stat(FDSC_ST_BUSY, 1'b0);
        rdy_s <= 1'b1; wp_s <= 1'b1;
        cyc(3);
        cmd(FDSC_CMD_WRITE);
        wait_irq();
        check(wgate, 1'b0);
        stat(FDSC_ST_WPROT, 1'b1);
        wp_s <= 1'b0;
        cyc(3);
        cmd(FDSC_CMD_WRITE);
        cyc(3);
        check(wgate, 1'b1);
        stat(FDSC_ST_BUSY, 1'b1);
        wf_s <= 1'b1;
        wait_irq();
        check(wgate, 1'b0);
        stat(FDSC_ST_WFAULT, 1'b1);
        wf_s <= 1'b0;
        cmd(FDSC_CMD_READ);
        cyc(3);
        check(wgate, 1'b0);
        stat(FDSC_ST_BUSY, 1'b1);
        cmd(FDSC_CMD_STOP);
        wait_irq();
        $display("test read write done");
        // Precompensation hints; early wins when both bits are set.
        // The hints only show on write data, so a write with data on is held open.
        apb(1'b1, FDSC_CTRL_ADDR, 32'h2);
        cmd(FDSC_CMD_WRITE);
        cyc(3);
        check(wdata, 1'b1);
        for (int v = 0; v < 4; v++)
        begin
            apb(1'b1, FDSC_PRECOMP_ADDR, v);
            cyc(1);
            check(early, v[0]);
            check(late, v[1] & !v[0]);
        end
        cmd(FDSC_CMD_STOP);
        wait_irq();
        check(wgate, 1'b0);
        check(wdata, 1'b0);
        apb(1'b1, FDSC_CTRL_ADDR, 32'h1);
        cyc(1);
        check(hload, 1'b1);
        cyc(8);
        stat(FDSC_ST_HEADENG, 1'b1);
        apb(1'b1, FDSC_CTRL_ADDR, 32'h0);
        cyc(3);
        stat(FDSC_ST_HEADENG, 1'b0);
        dens <= 1'b1;
        cyc(3);
        stat(FDSC_ST_SINGLE, 1'b1);
        dens <= 1'b0;
        cyc(3);
        stat(FDSC_ST_SINGLE, 1'b0);
        // A short index pulse is ignored, a long one is seen.
        idx_len <= 8'h03;
        cyc(1);
        idx_len <= 8'h00;
        cyc(8);
        stat(FDSC_ST_INDEX, 1'b0);
        idx_len <= 8'h14;
        cyc(1);
        idx_len <= 8'h00;
        cyc(8);
        stat(FDSC_ST_INDEX, 1'b1);
        apb(1'b0, 12'h020, 32'h0);
        check(last_err, 1'b1);
        check(pready, 1'b1);
        $display("test misc done");
        results();
    end
endmodule : fdsc_top_tb_top
